// file: pkg/tap_pkg.sv
// Package: shared constants for the test-access port and emulation control
// Assumes: both ends and the testbench import it
package tap_pkg;
  localparam int IR_W   = 5;
  localparam int EMU_W  = 40;
  localparam int BSR_W  = 16;
  localparam int REV_W  = 8;
  localparam int STAT_W = 32;
  localparam int TEL_W  = 32;
  localparam int TCK_HALF = 4;

  localparam logic [IR_W-1:0] IR_RESET   = 5'h1f;
  localparam logic [IR_W-1:0] OP_BYPASS  = 5'h1f;
  localparam logic [IR_W-1:0] OP_EXTEST  = 5'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE  = 5'h10;
  localparam logic [IR_W-1:0] OP_INTEST  = 5'h18;
  localparam logic [IR_W-1:0] OP_BREAKPOINT_STATUS_PATH = 5'h1c;
  localparam logic [IR_W-1:0] OP_TEL_IN  = 5'h09;
  localparam logic [IR_W-1:0] OP_TEL_OUT = 5'h0b;
  localparam logic [IR_W-1:0] OP_REV     = 5'h1d;
  localparam logic [IR_W-1:0] OP_EMULATION_CONTROL  = 5'h0c;

  localparam int B_EMU_EN   = 0;
  localparam int B_IRQ_EN   = 1;
  localparam int B_BK_STOP  = 2;
  localparam int B_STEP     = 3;
  localparam int B_SYS_RST  = 4;
  localparam int B_BRK_PIN  = 5;
  localparam int B_DMA_HALT = 6;

  localparam logic [EMU_W-1:0] EMU_RESET = 40'h00_0000_0000;
  localparam logic [REV_W-1:0] REV_ID    = 8'h5a; // Arbitrary value

  typedef enum logic [3:0] {
    S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h3, S_CAP_DR = 4'h2,
    S_SH_DR = 4'h6, S_EX1_DR = 4'h7, S_PAU_DR = 4'h5, S_EX2_DR = 4'h4,
    S_UPD_DR = 4'hc, S_SEL_IR = 4'hd, S_CAP_IR = 4'hf, S_SH_IR = 4'he,
    S_EX1_IR = 4'ha, S_PAU_IR = 4'hb, S_EX2_IR = 4'h9, S_UPD_IR = 4'h8
  } tap_state_t;

  typedef enum logic [2:0] {
    P_BYPASS = 3'h0, P_BOUNDARY = 3'h1, P_BREAKPOINT_STATUS_PATH = 3'h2,
    P_TEL_IN = 3'h3, P_TEL_OUT = 3'h4, P_REV = 3'h5, P_EMULATION_CONTROL = 3'h6
  } scan_path_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_HIGH = 2'h1, H_LOW = 2'h3
  } host_state_t;
endpackage : tap_pkg

// file: pkg/tap_if.sv
// Interface: the five test-access pins between emulator and device
// Assumes: the bench drives the same mclk into both ends
`timescale 1ns/1ps
`default_nettype none
interface tap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic trst_n;
  modport device (input tck, input tms, input tdi, input trst_n, output tdo);
  modport host   (output tck, output tms, output tdi, output trst_n, input tdo);
endinterface : tap_if
`default_nettype wire

// file: hdl/tap_device.sv
// Device end: TAP controller, instruction decode, scan paths, emulation control
// Assumes: mclk is the core clock; all pins arrive asynchronous to it
`timescale 1ns/1ps
`default_nettype none
module tap_device
  import tap_pkg::*;
#(
  parameter int BSR_LEN = tap_pkg::BSR_W
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  tap_if.device                     pins,
  input  wire logic [BSR_LEN-1:0]   pin_sample,
  input  wire logic [tap_pkg::STAT_W-1:0] brk_status,
  input  wire logic [tap_pkg::TEL_W-1:0]  tel_out_data,
  input  wire logic                 breakpoint_hit,
  input  wire logic                 emu_irq_req,
  input  wire logic                 in_emu_space,
  input  wire logic                 dma_req_in,
  input  wire logic                 dma_granted,
  input  wire logic                 serial_port_unit_rx_valid,
  input  wire logic                 wbuf_pending,
  output logic [BSR_LEN-1:0]        pin_drive,
  output logic                      in_mode,
  output logic                      out_mode,
  output logic [tap_pkg::TEL_W-1:0] tel_in_data,
  output logic                      tel_in_strobe,
  output logic                      emu_irq,
  output logic                      step_mode,
  output logic                      core_reset,
  output logic                      break_out_n,
  output logic                      break_out_oe,
  output logic                      dma_req_out,
  output logic                      serial_port_unit_overrun,
  output logic                      wbuf_drain
);
  import tap_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] s1_q, s2_q;
  logic       tck_prev_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      // Idle clock level with test reset asserted, so no false edge follows reset
      s1_q       <= '0;
      s2_q       <= '0;
      tck_prev_q <= 1'b0;
    end else begin
      s1_q       <= {pins.tck, pins.tms, pins.tdi, pins.trst_n};
      s2_q       <= s1_q;
      tck_prev_q <= s2_q[3];
    end
  end
  wire logic tck_s  = s2_q[3];
  wire logic tms_s  = s2_q[2];
  wire logic tdi_s  = s2_q[1];
  wire logic trst_s = ~s2_q[0];
  wire logic rise   = tck_s & ~tck_prev_q;
  wire logic fall   = ~tck_s & tck_prev_q;

  // ----------------------------------------
  // TAP state machine
  // ----------------------------------------
  tap_state_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_RESET:  st_d = tms_s ? S_RESET  : S_IDLE;
      S_IDLE:   st_d = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_DR: st_d = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  st_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: st_d = tms_s ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: st_d = tms_s ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: st_d = tms_s ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: st_d = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_IR: st_d = tms_s ? S_RESET  : S_CAP_IR;
      S_CAP_IR: st_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  st_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: st_d = tms_s ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: st_d = tms_s ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: st_d = tms_s ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: st_d = tms_s ? S_SEL_DR : S_IDLE;
      default:  st_d = S_RESET;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst || trst_s) begin
      st_q <= S_RESET;
    end else if (rise) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Instruction register and decode
  // ----------------------------------------
  logic [IR_W-1:0] ir_sh_q, ir_q;
  always_ff @(posedge mclk) begin
    if (srst || trst_s || st_q == S_RESET) begin
      ir_q    <= IR_RESET;
      ir_sh_q <= IR_RESET;
    end else if (rise) begin
      if (st_q == S_CAP_IR) begin
        ir_sh_q <= {{(IR_W-1){1'b0}}, 1'b1};
      end else if (st_q == S_SH_IR) begin
        ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
      end else if (st_q == S_UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // Unlisted and unsupported codes fall back to bypass
  scan_path_t path;
  always_comb begin
    if (ir_q == OP_EXTEST || ir_q == OP_SAMPLE || ir_q == OP_INTEST) begin
      path = P_BOUNDARY;
    end else if (ir_q == OP_BREAKPOINT_STATUS_PATH) begin
      path = P_BREAKPOINT_STATUS_PATH;
    end else if (ir_q == OP_TEL_IN) begin
      path = P_TEL_IN;
    end else if (ir_q == OP_TEL_OUT) begin
      path = P_TEL_OUT;
    end else if (ir_q == OP_REV) begin
      path = P_REV;
    end else if (ir_q == OP_EMULATION_CONTROL) begin
      path = P_EMULATION_CONTROL;
    end else begin
      path = P_BYPASS;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      in_mode  <= 1'b0;
      out_mode <= 1'b0;
    end else begin
      in_mode  <= (ir_q == OP_INTEST);
      out_mode <= (ir_q == OP_INTEST) || (ir_q == OP_EXTEST);
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  logic                byp_q;
  logic [BSR_LEN-1:0]  bsr_q;
  logic [EMU_W-1:0]    dr_q;
  logic [EMU_W-1:0]    emu_q;
  wire logic cap = rise && st_q == S_CAP_DR;
  wire logic shf = rise && st_q == S_SH_DR;
  wire logic upd = rise && st_q == S_UPD_DR;

  always_ff @(posedge mclk) begin
    if (srst) begin
      byp_q <= 1'b0;
    end else if (cap && path == P_BYPASS) begin
      byp_q <= 1'b0;
    end else if (shf && path == P_BYPASS) begin
      byp_q <= tdi_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bsr_q <= '0;
    end else if (cap && path == P_BOUNDARY) begin
      bsr_q <= pin_sample;
    end else if (shf && path == P_BOUNDARY) begin
      bsr_q <= {tdi_s, bsr_q[BSR_LEN-1:1]};
    end
  end

  // One shared shift register serves every path except bypass and boundary
  always_ff @(posedge mclk) begin
    if (srst) begin
      dr_q <= '0;
    end else if (cap) begin
      case (path)
        P_BREAKPOINT_STATUS_PATH: dr_q <= {{(EMU_W-STAT_W){1'b0}}, brk_status};
        P_TEL_OUT: dr_q <= {{(EMU_W-TEL_W){1'b0}}, tel_out_data};
        P_REV:     dr_q <= {{(EMU_W-REV_W){1'b0}}, REV_ID};
        P_EMULATION_CONTROL:  dr_q <= emu_q;
        default:   dr_q <= '0;
      endcase
    end else if (shf) begin
      dr_q <= {tdi_s, dr_q[EMU_W-1:1]};
    end
  end

  // Control only changes on update, so shifting never disturbs it
  always_ff @(posedge mclk) begin
    if (srst || trst_s) begin
      emu_q <= EMU_RESET;
    end else if (upd && path == P_EMULATION_CONTROL) begin
      emu_q <= dr_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_drive     <= '0;
      tel_in_data   <= '0;
      tel_in_strobe <= 1'b0;
    end else begin
      tel_in_strobe <= upd && path == P_TEL_IN;
      if (upd && path == P_TEL_IN) begin
        // Shifted bits enter at the top, so a short path ends in the upper bits
        tel_in_data <= dr_q[EMU_W-1 -: TEL_W];
      end
      if (upd && path == P_BOUNDARY) begin
        pin_drive <= bsr_q;
      end
    end
  end

  // ----------------------------------------
  // Serial output, changes on falling test clock
  // ----------------------------------------
  logic tdo_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      tdo_q <= 1'b0;
    end else if (fall) begin
      if (st_q == S_SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (st_q == S_SH_DR) begin
        case (path)
          P_BYPASS:   tdo_q <= byp_q;
          P_BOUNDARY: tdo_q <= bsr_q[0];
          default:    tdo_q <= dr_q[0];
        endcase
      end
    end
  end
  assign pins.tdo = tdo_q;

  // ----------------------------------------
  // Emulation control effects on the core
  // ----------------------------------------
  wire logic halt = emu_q[B_DMA_HALT] && in_emu_space;
  wire logic brk  = emu_q[B_EMU_EN] && breakpoint_hit;
  always_ff @(posedge mclk) begin
    if (srst) begin
      emu_irq       <= 1'b0;
      step_mode     <= 1'b0;
      core_reset    <= 1'b0;
      break_out_n   <= 1'b1;
      break_out_oe  <= 1'b0;
      dma_req_out   <= 1'b0;
      serial_port_unit_overrun <= 1'b0;
      wbuf_drain    <= 1'b0;
    end else begin
      emu_irq <= emu_q[B_EMU_EN] && emu_q[B_IRQ_EN]
                 && (emu_irq_req || (emu_q[B_BK_STOP] && breakpoint_hit));
      step_mode    <= emu_q[B_STEP];
      core_reset   <= emu_q[B_SYS_RST];
      break_out_oe <= emu_q[B_BRK_PIN];
      break_out_n  <= ~brk;
      dma_req_out  <= dma_req_in && (!halt || dma_granted);
      wbuf_drain   <= wbuf_pending;
      // Sticky until reset; the set can never be lost
      if (halt && serial_port_unit_rx_valid) begin
        serial_port_unit_overrun <= 1'b1;
      end
    end
  end
endmodule : tap_device
`default_nettype wire

// file: hdl/tap_host.sv
// Emulator end: runs scans on the TAP from a simple command port
// Assumes: software drives the register port one strobe per cycle
`timescale 1ns/1ps
`default_nettype none
module tap_host
  import tap_pkg::*;
#(
  parameter int HALF = tap_pkg::TCK_HALF
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  tap_if.host              pins,
  input  wire logic [1:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  import tap_pkg::*;

  // Offsets: 0 = tms/tdi bits, 1 = go (count), 2 = tdo capture, 3 = status
  localparam logic [1:0] A_SEQ = 2'h0;
  localparam logic [1:0] A_GO  = 2'h1;
  localparam logic [1:0] A_TDO = 2'h2;
  localparam logic [1:0] A_STS = 2'h3;

  logic [31:0] tms_q, tdi_q, tdo_cap_q;
  logic [5:0]  cnt_q;
  logic [7:0]  div_q;
  logic        sync1_q, sync2_q;
  logic        trst_n_q;
  logic        tck_q;
  host_state_t hs_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pins.tdo;
      sync2_q <= sync1_q;
    end
  end

  // Bits go out LSB first, one per test clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      hs_q <= H_IDLE; cnt_q <= '0; div_q <= '0; tms_q <= '0; tdi_q <= '0;
      tdo_cap_q <= '0;
      trst_n_q <= 1'b0;
      tck_q <= 1'b0;
    end else begin
      if (wr && addr == A_SEQ) begin
        tms_q  <= {16'h0000, wdata[15:0]};
        tdi_q  <= {16'h0000, wdata[31:16]};
        trst_n_q <= 1'b1;
      end
      case (hs_q)
        H_IDLE: if (wr && addr == A_GO && wdata[5:0] != 6'h00) begin
          cnt_q <= wdata[5:0]; div_q <= '0; hs_q <= H_LOW;
        end
        H_LOW: if (div_q == 8'(HALF - 1)) begin
          div_q <= '0; hs_q <= H_HIGH;
          tck_q <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
        H_HIGH: if (div_q == 8'(HALF - 1)) begin
          div_q <= '0; cnt_q <= cnt_q - 6'h01;
          // Sampled late in the high phase: the round trip through both synchronisers outlasts a low phase
          tdo_cap_q <= {sync2_q, tdo_cap_q[31:1]};
          tck_q <= 1'b0;
          tms_q <= {1'b0, tms_q[31:1]}; tdi_q <= {1'b0, tdi_q[31:1]};
          hs_q <= (cnt_q == 6'h01) ? H_IDLE : H_LOW;
        end else begin
          div_q <= div_q + 8'h01;
        end
        default: begin
          hs_q <= H_IDLE;
          tck_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= '0;
    end else if (rd) begin
      if (addr == A_TDO) begin
        rdata <= tdo_cap_q;
      end else if (addr == A_STS) begin
        rdata <= {26'h0, cnt_q};
      end else begin
        rdata <= '0;
      end
    end else begin
      rdata <= '0;
    end
  end

  // Software may issue unlisted codes too; the bench sends 5'h03, which the device decodes as bypass
  assign pins.tck    = tck_q;
  assign pins.tms    = tms_q[0];
  assign pins.tdi    = tdi_q[0];
  assign pins.trst_n = trst_n_q;
endmodule : tap_host
`default_nettype wire

// file: bench/tap_properties.sv
// Checker: timing of the five test-access pins between the two ends
// Assumes: instantiated beside tap_if, sampled on the shared mclk
`timescale 1ns/1ps
`default_nettype none
module tap_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic trst_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // ---------------------------------------------
  // Divided test clock, four cycles a phase
  // ---------------------------------------------
  sequence high_phase;
    tck [*4];
  endsequence
  sequence low_phase;
    !tck [*4];
  endsequence

  a_tck_high_len: assert property ($rose(tck) |-> high_phase ##1 !tck)
    else $error("tck high phase has the wrong length");
  a_tck_low_len: assert property ($fell(tck) |-> low_phase)
    else $error("tck low phase too short");
  // Pins move only in the low phase, so the far end sees settled levels
  a_pins_hold: assert property ($changed(tms) || $changed(tdi) |-> !tck)
    else $error("tms or tdi changed while tck high");
  a_tdo_after_fall: assert property ($changed(tdo) |-> !tck && !$past(tck))
    else $error("tdo changed outside the low phase");
  a_trst_release: assert property ($rose(trst_n) |-> !tck)
    else $error("trst_n released with tck high");
  a_trst_quiet: assert property (!trst_n |-> !tck)
    else $error("tck pulsed during test reset");
  a_reset_trst: assert property ($fell(srst) |-> !trst_n)
    else $error("trst_n not held after reset");
  a_trst_sticky: assert property (!$fell(trst_n))
    else $error("trst_n fell outside reset");
endmodule : tap_properties
`default_nettype wire

// file: bench/tb_jtag_emulation_control.sv
// Testbench: scans driven through the host register port into the device end
// Assumes: both ends share mclk; device side inputs are driven here
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_emulation_control;
  import tap_pkg::*;
  logic mclk, srst, wr, rd, bp_hit, irq_req, emu_sp, dma_in, sp_rx, wb_pend;
  logic [1:0] addr;
  logic [31:0] wdata, rdata;
  logic [BSR_W-1:0] pin_sample, pin_drive;
  logic [STAT_W-1:0] brk_status;
  logic [TEL_W-1:0] tel_out_data, tel_in_data;
  logic in_mode, out_mode, emu_irq, step_mode, core_reset, break_out_oe, dma_req_out, serial_port_unit_overrun, wbuf_drain;
  logic break_out_n, tel_in_strobe, dma_gnt;
  logic [47:0] v, e, m;
  logic [47:0] pat = 48'h3c_9696_a5a5;
  logic [4:0] codes [9] = '{OP_BYPASS, 5'h03, OP_EXTEST, OP_SAMPLE, OP_INTEST, OP_BREAKPOINT_STATUS_PATH, OP_TEL_IN, OP_TEL_OUT, OP_REV};
  int lens [9] = '{8, 8, 16, 16, 16, 32, 32, 32, 8};
  logic [7:0] ictl [5] = '{8'h03, 8'h02, 8'h01, 8'h07, 8'h03};
  logic [4:0] ireq = 5'b00111;
  logic [4:0] ibp = 5'b11000;
  logic [4:0] iexp = 5'b01001;
  int n_errors = 0;
  int cmp_count = 0;
  int n_tel = 0;

  tap_if tif ();
  tap_host tap_host_i (.mclk(mclk), .srst(srst), .pins(tif), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  tap_device tap_device_i (.mclk(mclk), .srst(srst), .pins(tif), .pin_sample(pin_sample), .brk_status(brk_status),
    .tel_out_data(tel_out_data), .breakpoint_hit(bp_hit), .emu_irq_req(irq_req), .in_emu_space(emu_sp),
    .dma_req_in(dma_in), .dma_granted(dma_gnt), .serial_port_unit_rx_valid(sp_rx), .wbuf_pending(wb_pend),
    .pin_drive(pin_drive), .in_mode(in_mode), .out_mode(out_mode), .tel_in_data(tel_in_data),
    .tel_in_strobe(tel_in_strobe), .emu_irq(emu_irq), .step_mode(step_mode), .core_reset(core_reset),
    .break_out_n(break_out_n),
    .break_out_oe(break_out_oe), .dma_req_out(dma_req_out), .serial_port_unit_overrun(serial_port_unit_overrun), .wbuf_drain(wbuf_drain));
  tap_properties tap_properties_i (.mclk(mclk), .srst(srst), .tck(tif.tck), .tms(tif.tms), .tdi(tif.tdi),
    .tdo(tif.tdo), .trst_n(tif.trst_n));

  // One-cycle strobe: counted, since a single look could miss it
  always @(posedge mclk) if (tel_in_strobe) n_tel <= n_tel + 1;

  // ---------------------------------------------
  // Register port and scan helpers
  // ---------------------------------------------
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Sixteen bits per go command; tck stands still between chunks
  task automatic run(input logic [63:0] tms, input logic [63:0] tdi, input int n, output logic [63:0] tdo);
    logic [31:0] d;
    int c;
    tdo = '0;
    for (int p = 0; p < n; p += 16) begin
      c = (n - p > 16) ? 16 : n - p;
      wr_reg(2'h0, {tdi[p +: 16], tms[p +: 16]});
      wr_reg(2'h1, 32'(c));
      d = 32'h1;
      for (int k = 0; k < 500 && d != 32'h0; k++) rd_reg(2'h3, d);
      check("scan done", 48'(d), 48'h0);
      rd_reg(2'h2, d);
      for (int i = 0; i < c; i++) tdo[p + i] = d[32 - c + i];
    end
  endtask : run

  task automatic ir(input logic [4:0] code);
    logic [63:0] t;
    run(64'h0303, 64'(code) << 4, 11, t);
  endtask : ir

  task automatic dr(input int n, input logic [47:0] din, output logic [47:0] dout);
    logic [63:0] t;
    run(64'h1 | (64'h3 << (n + 2)), 64'(din) << 3, n + 5, t);
    dout = 48'(t >> 3) & ((48'h1 << n) - 48'h1);
  endtask : dr

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    repeat (80000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    {wr, rd, bp_hit, irq_req, emu_sp, dma_in, sp_rx, wb_pend, dma_gnt} = '0;
    addr = 2'h0;
    wdata = 32'h0;
    pin_sample = 16'hc3a5;
    brk_status = 32'h1234_5678;
    tel_out_data = 32'h9abc_def0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      run(64'h0, 64'h0, 1, v);
      dr(8, pat & 48'hff, v);
      check("bypass after reset", v, (pat << 1) & 48'hff);
      if (r == 1) break;
      for (int i = 0; i < 9; i++) begin
        ir(codes[i]);
        check("in_mode", 48'(in_mode), 48'(codes[i] == OP_INTEST));
        check("out_mode", 48'(out_mode), 48'(codes[i] inside {OP_EXTEST, OP_INTEST}));
        m = (48'h1 << lens[i]) - 48'h1;
        dr(lens[i], pat & m, v);
        case (codes[i])
          OP_BYPASS, 5'h03: e = (pat << 1) & m;
          OP_BREAKPOINT_STATUS_PATH: e = 48'(brk_status);
          OP_TEL_IN: e = 48'h0;
          OP_TEL_OUT: e = 48'(tel_out_data);
          OP_REV: e = 48'(REV_ID);
          default: begin
            e = 48'(pin_sample);
            check("pin_drive", 48'(pin_drive), pat & m);
          end
        endcase
        check("scan path", v, e);
      end
      check("tel_in_data", 48'(tel_in_data), pat & 48'hffff_ffff);
      check("tel_in_strobe", 48'(n_tel), 48'h1);
      ir(OP_EMULATION_CONTROL);
      dr(40, 48'h38, v);
      check("step_mode", 48'(step_mode), 48'h1);
      check("break_out_oe", 48'(break_out_oe), 48'h1);
      repeat (60) @(posedge mclk);
      check("core_reset", 48'(core_reset), 48'h1);
      dr(40, 48'h0, v);
      check("control capture", v, 48'h38);
      check("core_reset cleared", 48'(core_reset | step_mode | break_out_oe), 48'h0);
      check("break_out_n idle", 48'(break_out_n), 48'h1);
      for (int i = 0; i < 5; i++) begin
        @(posedge mclk);
        irq_req <= ireq[i];
        bp_hit <= ibp[i];
        dr(40, 48'(ictl[i]), v);
        check("emu_irq", 48'(emu_irq), 48'(iexp[i]));
      end
      check("break_out_n", 48'(break_out_n), 48'h0);
      @(posedge mclk);
      {dma_in, sp_rx, wb_pend, irq_req, bp_hit} <= 5'b11100;
      dr(40, 48'h50, v);
      check("dma outside emu", 48'({dma_req_out, serial_port_unit_overrun}), 48'h2);
      @(posedge mclk);
      emu_sp <= 1'b1;
      repeat (8) @(posedge mclk);
      check("dma halted", 48'({dma_req_out, serial_port_unit_overrun, wbuf_drain}), 48'h3);
      dma_gnt <= 1'b1;
      repeat (2) @(posedge mclk);
      check("dma granted", 48'(dma_req_out), 48'h1);
      dma_gnt <= 1'b0;
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      check("after srst", 48'({core_reset, serial_port_unit_overrun}), 48'h0);
    end
    wrap_up();
  end
endmodule : tb_jtag_emulation_control
`default_nettype wire
